// *** src/ctp_amp_ctrl.sv ***
// Clip threshold registers, control port slave, serial audio capture and clipper.
`default_nettype none
// Contract
// - The clipping threshold is one 20-bit value built from high, middle and low register slices.
// - The register at 0x10 holds threshold bits 13:6 and resets to all ones.
// - Bits 7:2 of the next register hold threshold bits 5:0.
// - The device is in shutdown when the shutdown pin is low or the shutdown bit is cleared.
// - In software control the output clipping point follows the programmed threshold.

// ****************************************************************
// Stream buffer.
// ****************************************************************
module ctp_fifo #(
  parameter int W = 25,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;

  assign empty = wr_ptr_ff == rd_ptr_ff;
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// Amplifier control top.
// ****************************************************************
module ctp_amp_ctrl #(
  parameter logic [6:0] DEV_ADDR = ctp_pkg::DEF_DEV_ADDR,
  parameter int DEPTH = ctp_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic adr_sel,
  input wire logic amp_shutdown_n,
  input wire logic [1:0] speaker_gain_select,
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sdin,
  output logic amp_active,
  output logic amp_muted,
  output logic out_valid,
  input wire logic out_ready,
  output logic [ctp_pkg::SAMPLE_W-1:0] out_sample,
  output logic out_right
);
  localparam int SW = ctp_pkg::SAMPLE_W;

  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h3, I_RX = 3'h2,
    I_RACK = 3'h6, I_TX = 3'h7, I_TACK = 3'h5
  } ctp_i2c_e;

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  // Every outside pin passes two flops; only stage two is read.
  localparam int NS = 9;
  // The control port lines rest high, so their stages reset high; a low reset fakes an edge.
  localparam logic [NS-1:0] SYNC_IDLE = 9'h003;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_ff;
  logic [NS-1:0] sync2_ff;
  assign pin_raw = {speaker_gain_select, adr_sel, amp_shutdown_n, sdin, lrclk, bclk, sda_i, scl_i};

  genvar gi;
  for (gi = 0; gi < NS; gi++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        sync1_ff[gi] <= SYNC_IDLE[gi];
        sync2_ff[gi] <= SYNC_IDLE[gi];
      end else begin
        sync1_ff[gi] <= pin_raw[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
  end

  logic scl_s, sda_s, bclk_s, lr_s, sdin_s, sd_pin_s, adr_s;
  logic [1:0] gain_s;
  assign {gain_s, adr_s, sd_pin_s, sdin_s, lr_s, bclk_s, sda_s, scl_s} = sync2_ff;

  logic scl_q_ff, sda_q_ff, bclk_q_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      bclk_q_ff <= 1'b0;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      bclk_q_ff <= bclk_s;
    end
  end

  // ****************************************************************
  // Control port slave.
  // ****************************************************************
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise = scl_s && !scl_q_ff;
  assign scl_fall = !scl_s && scl_q_ff;
  assign i2c_start = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  assign i2c_stop = scl_s && scl_q_ff && !sda_q_ff && sda_s;

  ctp_i2c_e i2c_st_ff;
  logic [7:0] shift_ff, ptr_ff, rdata, wr_addr_ff, wr_data_ff;
  logic [3:0] cnt_ff;
  logic rw_ff, first_ff, ack_ok_ff, wr_stb_ff;
  logic [7:0] thr_mid_ff, thr_low_ff, thr_high_ff, ctrl_ff;
  logic ovr_ff, sw_mode;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      i2c_st_ff <= I_IDLE;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      cnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      wr_stb_ff <= 1'b0;
      if (i2c_start) begin
        i2c_st_ff <= I_ADDR;
        cnt_ff <= 4'h0;
      end else if (i2c_stop) begin
        i2c_st_ff <= I_IDLE;
      end else begin
        case (i2c_st_ff)
          I_ADDR, I_RX: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == 4'h8) begin
              cnt_ff <= 4'h0;
              if (i2c_st_ff == I_ADDR) begin
                rw_ff <= shift_ff[0];
                i2c_st_ff <= (shift_ff[7:1] == {DEV_ADDR[6:1], adr_s}) ? I_AACK : I_IDLE;
              end else begin
                i2c_st_ff <= I_RACK;
                first_ff <= 1'b0;
                if (first_ff) begin
                  ptr_ff <= shift_ff;
                end else begin
                  wr_stb_ff <= 1'b1;
                  wr_addr_ff <= ptr_ff;
                  wr_data_ff <= shift_ff;
                  ptr_ff <= ptr_ff + 8'h01;
                end
              end
            end
          end
          I_AACK, I_RACK: begin
            if (scl_fall) begin
              if (i2c_st_ff == I_AACK && rw_ff) begin
                i2c_st_ff <= I_TX;
                shift_ff <= rdata;
                ptr_ff <= ptr_ff + 8'h01;
              end else begin
                i2c_st_ff <= I_RX;
                first_ff <= i2c_st_ff == I_AACK;
              end
            end
          end
          I_TX: begin
            if (scl_fall) begin
              if (cnt_ff == 4'h7) begin
                i2c_st_ff <= I_TACK;
                cnt_ff <= 4'h0;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'b0};
                cnt_ff <= cnt_ff + 4'h1;
              end
            end
          end
          I_TACK: begin
            if (scl_rise) begin
              ack_ok_ff <= !sda_s;
            end else if (scl_fall) begin
              if (ack_ok_ff) begin
                i2c_st_ff <= I_TX;
                shift_ff <= rdata;
                ptr_ff <= ptr_ff + 8'h01;
              end else begin
                i2c_st_ff <= I_IDLE;
              end
            end
          end
          default: i2c_st_ff <= I_IDLE;
        endcase
      end
    end
  end

  // Open drain: the line is only ever pulled low, never driven high.
  assign sda_o = 1'b0;
  assign sda_oe_n = !(i2c_st_ff == I_AACK || i2c_st_ff == I_RACK ||
    (i2c_st_ff == I_TX && !shift_ff[7]));

  // ****************************************************************
  // Register file.
  // ****************************************************************
  logic [ctp_pkg::THR_W-1:0] clip_threshold;
  assign clip_threshold = {thr_high_ff[5:0], thr_mid_ff,
    thr_low_ff[7:ctp_pkg::THR_LOW_LSB]};

  logic ovr_set;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_ff <= ctp_pkg::RST_CTRL;
      thr_mid_ff <= ctp_pkg::RST_THR_MID;
      thr_low_ff <= ctp_pkg::RST_THR_LOW;
      thr_high_ff <= ctp_pkg::RST_THR_HIGH;
    end else if (wr_stb_ff) begin
      case (wr_addr_ff)
        ctp_pkg::OFF_CTRL: ctrl_ff <= wr_data_ff;
        ctp_pkg::OFF_THR_MID: thr_mid_ff <= wr_data_ff;
        ctp_pkg::OFF_THR_LOW: thr_low_ff <= wr_data_ff;
        ctp_pkg::OFF_THR_HIGH: thr_high_ff <= {2'h0, wr_data_ff[5:0]};
        default: ;
      endcase
    end
  end

  // Overrun is sticky; a new overrun in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovr_ff <= 1'b0;
    end else if (ovr_set) begin
      ovr_ff <= 1'b1;
    end else if (wr_stb_ff && wr_addr_ff == ctp_pkg::OFF_STAT && wr_data_ff[ctp_pkg::STAT_OVR_BIT]) begin
      ovr_ff <= 1'b0;
    end
  end

  always_comb begin
    rdata = 8'h00;
    case (ptr_ff)
      ctp_pkg::OFF_CTRL: rdata = ctrl_ff;
      ctp_pkg::OFF_STAT: begin
        rdata[ctp_pkg::STAT_ACTIVE_BIT] = amp_active;
        rdata[ctp_pkg::STAT_OVR_BIT] = ovr_ff;
        rdata[ctp_pkg::STAT_SWMODE_BIT] = sw_mode;
      end
      ctp_pkg::OFF_THR_MID: rdata = thr_mid_ff;
      ctp_pkg::OFF_THR_LOW: rdata = thr_low_ff;
      ctp_pkg::OFF_THR_HIGH: rdata = thr_high_ff;
      default: rdata = 8'h00;
    endcase
  end

  // ****************************************************************
  // Power state.
  // ****************************************************************
  assign sw_mode = gain_s == ctp_pkg::GAIN_SW_MODE;
  assign amp_active = sd_pin_s && ctrl_ff[ctp_pkg::CTRL_RUN_BIT];
  assign amp_muted = ctrl_ff[ctp_pkg::CTRL_MUTE_BIT];

  // ****************************************************************
  // Serial audio capture and clipper.
  // ****************************************************************
  // Words are taken MSB first, one bit after each frame edge; only the
  // top SAMPLE_W bits are kept and shorter words are not supported.
  logic bclk_rise;
  assign bclk_rise = bclk_s && !bclk_q_ff;
  logic lr_last_ff, cap_ff, cap_right_ff;
  logic [4:0] bit_cnt_ff;
  logic [SW-1:0] aud_shift_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lr_last_ff <= 1'b0;
      bit_cnt_ff <= 5'h1f;
      aud_shift_ff <= '0;
      cap_ff <= 1'b0;
      cap_right_ff <= 1'b0;
    end else begin
      cap_ff <= 1'b0;
      if (bclk_rise) begin
        lr_last_ff <= lr_s;
        if (lr_s != lr_last_ff) begin
          bit_cnt_ff <= 5'h0;
        end else if (bit_cnt_ff < 5'(SW)) begin
          aud_shift_ff <= {aud_shift_ff[SW-2:0], sdin_s};
          bit_cnt_ff <= bit_cnt_ff + 5'h1;
          cap_ff <= bit_cnt_ff == 5'(SW - 1);
          cap_right_ff <= lr_s;
        end
      end
    end
  end

  logic signed [SW-1:0] pos_lim, neg_lim, smp, clipped;
  always_comb begin
    pos_lim = {{(SW - ctp_pkg::THR_W){1'b0}}, clip_threshold};
    neg_lim = -pos_lim;
    smp = aud_shift_ff;
    clipped = smp;
    if (sw_mode && smp > pos_lim) begin
      clipped = pos_lim;
    end else if (sw_mode && smp < neg_lim) begin
      clipped = neg_lim;
    end
    if (amp_muted) begin
      clipped = '0;
    end
  end

  // Audio cannot be stalled, so a full buffer drops the sample and flags it.
  logic push, push_ready;
  assign push = cap_ff && amp_active;
  assign ovr_set = push && !push_ready;

  ctp_fifo #(.W(SW + 1), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data({cap_right_ff, clipped}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_right, out_sample})
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_wr_mid;
    wr_stb_ff && wr_addr_ff == ctp_pkg::OFF_THR_MID;
  endsequence
  sequence s_wr_low;
    wr_stb_ff && wr_addr_ff == ctp_pkg::OFF_THR_LOW;
  endsequence

  a_mid_write_map: assert property (@(posedge sys_clk) disable iff (reset)
    s_wr_mid |=> clip_threshold[13:6] == $past(wr_data_ff))
    else $error("Middle threshold slice did not take the write.");
  a_low_write_map: assert property (@(posedge sys_clk) disable iff (reset)
    s_wr_low |=> clip_threshold[5:0] == $past(wr_data_ff[7:2]))
    else $error("Low threshold slice did not take bits 7 to 2.");
  a_thr_reset_val: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> clip_threshold == 20'hfffff)
    else $error("Threshold reset value is wrong.");
  a_pin_shutdown: assert property (@(posedge sys_clk) disable iff (reset)
    !amp_shutdown_n [*3] |-> !amp_active)
    else $error("Device active with shutdown pin low.");
  a_bit_shutdown: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl_ff[ctp_pkg::CTRL_RUN_BIT] |-> !amp_active && !push)
    else $error("Device active with shutdown bit cleared.");
  a_clip_limit: assert property (@(posedge sys_clk) disable iff (reset)
    cap_ff && sw_mode && !amp_muted && smp > pos_lim |-> clipped == 24'(clip_threshold))
    else $error("Positive sample not saturated to threshold.");
  a_clip_floor: assert property (@(posedge sys_clk) disable iff (reset)
    cap_ff && sw_mode && !amp_muted && smp < neg_lim |-> clipped == -24'(clip_threshold))
    else $error("Negative sample not saturated to threshold.");
  a_clip_pass: assert property (@(posedge sys_clk) disable iff (reset)
    cap_ff && !amp_muted && smp <= pos_lim && smp >= neg_lim |-> clipped == smp)
    else $error("Sample inside threshold was altered.");
endmodule
`default_nettype wire

// *** src/ctp_pkg.sv ***
// Shared constants for the clip threshold and power sequencing block.
`default_nettype none
package ctp_pkg;
  // Control port register offsets.
  localparam logic [7:0] OFF_CTRL = 8'h01;
  localparam logic [7:0] OFF_STAT = 8'h02;
  localparam logic [7:0] OFF_THR_MID = 8'h10;
  localparam logic [7:0] OFF_THR_LOW = 8'h11;
  localparam logic [7:0] OFF_THR_HIGH = 8'h12;
  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h02;
  localparam logic [7:0] RST_THR_MID = 8'hff;
  localparam logic [7:0] RST_THR_LOW = 8'hfc;
  localparam logic [7:0] RST_THR_HIGH = 8'h3f;
  // Field positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MUTE_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_SWMODE_BIT = 2;
  localparam int THR_W = 20;
  localparam int THR_LOW_LSB = 2;
  // Stream shape.
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] GAIN_SW_MODE = 2'h3;
  localparam logic [6:0] DEF_DEV_ADDR = 7'h2a;
endpackage
`default_nettype wire

// *** tb/ctp_amp_ctrl_tb.sv ***
// Testbench for the clip threshold and power sequencing block.
`default_nettype none
module ctp_amp_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADR = {ctp_pkg::DEF_DEV_ADDR[6:1], 1'b0};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic adr_sel = 1'b0;
  logic [1:0] gain = 2'h3;
  logic out_ready = 1'b0;
  logic scl, sda_pull, bclk, lrclk, sdin, sd_n, sda_o, sda_oe_n;
  logic amp_active, amp_muted, out_valid, out_right;
  logic [23:0] out_sample;
  wire sda_line = ~sda_pull & (sda_oe_n | sda_o);
  int err_total = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  ctp_amp_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .adr_sel(adr_sel), .amp_shutdown_n(sd_n),
    .speaker_gain_select(gain), .bclk(bclk), .lrclk(lrclk), .sdin(sdin),
    .amp_active(amp_active), .amp_muted(amp_muted), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample), .out_right(out_right));
  ctp_host_model u_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull), .bclk(bclk), .lrclk(lrclk), .sdin(sdin), .amp_shutdown_n(sd_n));
  // ****************************************************************
  // Access and compare tasks.
  // ****************************************************************
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic a0, a1, a2;
    u_host.start();
    u_host.wbyte({ADR, 1'b0}, a0);
    u_host.wbyte(off, a1);
    u_host.wbyte(d, a2);
    u_host.stop();
    chk("write ack", {a0, a1, a2}, 3'h0);
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    logic a0, a1, a2;
    logic [7:0] d;
    u_host.start();
    u_host.wbyte({ADR, 1'b0}, a0);
    u_host.wbyte(off, a1);
    u_host.start();
    u_host.wbyte({ADR, 1'b1}, a2);
    u_host.rbyte(d, 1'b1);
    u_host.stop();
    chk("read ack", {a0, a1, a2}, 3'h0);
    chk("register", d, e);
  endtask
  task automatic pop(input logic [23:0] e, input logic rt);
    for (int i = 0; i < 100 && out_valid !== 1'b1; i++) @(posedge sys_clk) #1;
    chk("sample", out_sample, e);
    chk("channel", out_right, rt);
    out_ready = 1'b1;
    @(posedge sys_clk) #1;
    out_ready = 1'b0;
    @(posedge sys_clk) #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    logic ack;
    repeat (12) @(posedge sys_clk);
    #1 reset = 1'b0;
    u_host.wt(5);
    chk("muted", amp_muted, 1'b1);
    chk("active", amp_active, 1'b0);
    chk("valid", out_valid, 1'b0);
    // Clocks start before programming; the opening word is lost while the frame locks.
    u_host.frame(24'h000000, 24'h000000);
    chk("valid", out_valid, 1'b0);
    rd(ctp_pkg::OFF_THR_MID, 8'hff);
    rd(ctp_pkg::OFF_THR_LOW, 8'hfc);
    rd(ctp_pkg::OFF_CTRL, ctp_pkg::RST_CTRL);
    u_host.start();
    u_host.wbyte({ADR ^ 7'h01, 1'b0}, ack);
    u_host.stop();
    chk("foreign address", ack, 1'b1);
    // Threshold of 0x01000 is programmed while still in shutdown.
    wr(ctp_pkg::OFF_THR_HIGH, 8'h00);
    wr(ctp_pkg::OFF_THR_MID, 8'h40);
    wr(ctp_pkg::OFF_THR_LOW, 8'h00);
    wr(ctp_pkg::OFF_CTRL, 8'h03);
    rd(ctp_pkg::OFF_THR_HIGH, 8'h00);
    rd(ctp_pkg::OFF_THR_MID, 8'h40);
    rd(ctp_pkg::OFF_THR_LOW, 8'h00);
    rd(8'h20, 8'h00);
    chk("active", amp_active, 1'b0);
    u_host.pin(1'b1);
    chk("active", amp_active, 1'b1);
    wr(ctp_pkg::OFF_CTRL, 8'h01);
    chk("muted", amp_muted, 1'b0);
    u_host.frame(24'h000800, 24'h400000);
    pop(24'h000800, 1'b0);
    pop(24'h001000, 1'b1);
    u_host.frame(24'hc00000, 24'h001000);
    pop(24'hfff000, 1'b0);
    pop(24'h001000, 1'b1);
    u_host.frame(24'hfffff0, 24'hffefff);
    pop(24'hfffff0, 1'b0);
    pop(24'hfff000, 1'b1);
    wr(ctp_pkg::OFF_CTRL, 8'h00);
    chk("active", amp_active, 1'b0);
    u_host.frame(24'h000001, 24'h000002);
    u_host.wt(10);
    chk("valid", out_valid, 1'b0);
    // Ten samples against eight places: the last two are dropped.
    wr(ctp_pkg::OFF_CTRL, 8'h01);
    for (int k = 0; k < 5; k++) u_host.frame(24'(2 * k), 24'(2 * k + 1));
    rd(ctp_pkg::OFF_STAT, 8'h07);
    for (int k = 0; k < 8; k++) pop(24'(k), k[0]);
    chk("valid", out_valid, 1'b0);
    wr(ctp_pkg::OFF_STAT, 8'h02);
    rd(ctp_pkg::OFF_STAT, 8'h05);
    wr(ctp_pkg::OFF_CTRL, 8'h03);
    u_host.frame(24'h000123, 24'h000456);
    pop(24'h000000, 1'b0);
    pop(24'h000000, 1'b1);
    u_host.pin(1'b0);
    chk("active", amp_active, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// *** tb/ctp_host_model.sv ***
// Host model: control port master, serial audio master and shutdown pin.
`default_nettype none
module ctp_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic bclk,
  output logic lrclk,
  output logic sdin,
  output logic amp_shutdown_n
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 5;
  // Shutdown is held from time zero, so supply order does not matter.
  initial begin
    amp_shutdown_n = 1'b0;
    scl = 1'b1;
    sda_pull = 1'b0;
    bclk = 1'b0;
    lrclk = 1'b1;
    sdin = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pin(input logic v);
    amp_shutdown_n = v;
    wt(4);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sda_pull = 1'b1;
    wt(Q);
    scl = 1'b0;
    wt(Q);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sda_pull = 1'b0;
    wt(Q);
  endtask
  task automatic clk_bit(input logic pull, output logic seen);
    sda_pull = pull;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    seen = sda_line;
    wt(Q);
    scl = 1'b0;
    wt(Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(~d[i], s);
    clk_bit(1'b0, ack);
  endtask
  task automatic rbyte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, d[i]);
    clk_bit(~last, s);
  endtask
  // The bit clock runs only inside frames and rests low between them.
  task automatic slot(input logic ch, input logic [23:0] d);
    lrclk = ch;
    #62.5 bclk = 1'b1;
    #62.5;
    for (int i = 23; i >= 0; i--) begin
      bclk = 1'b0;
      sdin = d[i];
      #62.5 bclk = 1'b1;
      #62.5;
    end
    for (int i = 0; i < 7; i++) begin
      bclk = 1'b0;
      sdin = ~sdin;
      #62.5 bclk = 1'b1;
      #62.5;
    end
    bclk = 1'b0;
  endtask
  task automatic frame(input logic [23:0] l, input logic [23:0] r);
    slot(1'b0, l);
    slot(1'b1, r);
    sdin = ~sdin;
  endtask
endmodule
`default_nettype wire
